//--- verilog/odsc_consts.svh
// Register offsets, field positions, reset values, ratio limits and auto trigger codes for the output sync block.
`ifndef ODSC_CONSTS_SVH
`define ODSC_CONSTS_SVH
`define ODSC_ADDR_W          12
`define ODSC_OFF_PDIV_RESET  12'h433
`define ODSC_OFF_PDIV_RATIO  12'h434
`define ODSC_OFF_SYNC_CFG    12'h435
`define ODSC_OFF_SYNC_MASK   12'h436
`define ODSC_OFF_SYNC_CMD    12'h440
`define ODSC_OFF_STATUS      12'h441
`define ODSC_RST_PDIV_RATIO  4'h0
`define ODSC_RST_SYNC_CFG    3'h0
`define ODSC_RST_SYNC_MASK   3'h0
`define ODSC_RST_PDIV_RESET  1'h0
`define ODSC_BIT_SRC_SEL     2
`define ODSC_BIT_LOOP_OVR    2
`define ODSC_BIT_MASK_B      1
`define ODSC_BIT_MASK_A      0
`define ODSC_BIT_PDIV_RESET  1
`define ODSC_BIT_SYNC_CMD    0
`define ODSC_RATIO_MIN       4'h2
`define ODSC_RATIO_MAX       4'hb
`define ODSC_AUTO_OFF        2'h0
`define ODSC_AUTO_FREQ       2'h1
`define ODSC_AUTO_PHASE      2'h2
`endif

//--- verilog/odsc_pkg.sv
// Types shared by the output divider sync control block.
package odsc_pkg;
	typedef enum logic [2:0] {
		ODSC_IDLE  = 3'b001,
		ODSC_ALIGN = 3'b010,
		ODSC_FIRE  = 3'b100
	} odsc_state_t;
endpackage : odsc_pkg

//--- verilog/odsc_top.sv
// Post-divider and channel divider sync control for the first output loop.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
`include "odsc_consts.svh"
module odsc_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_reset_n,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_loop_calibrated,
	input  wire logic        i_loop_locked,
	input  wire logic        i_dpll_freq_lock,
	input  wire logic        i_dpll_phase_lock,
	input  wire logic        i_ref_active,
	output logic      [3:0]  o_post_divider_ratio,
	output logic             o_post_divider_reset,
	output logic             o_post_divider_ratio_valid,
	output logic             o_channel_a_output_hold,
	output logic             o_channel_b_output_hold,
	output logic             o_sync_pulse,
	output logic             o_sync_armed
);
	logic [3:0] ratio_r;
	logic       pdiv_reset_r;
	logic       src_sel_r;
	logic [1:0] auto_r;
	logic       loop_ovr_r;
	logic       mask_a_r;
	logic       mask_b_r;
	logic       cmd_pend_r;
	logic       auto_done_r;
	logic       hold_a_r;
	logic       hold_b_r;
	logic       sync_r;
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic       ref_prev_r;
	odsc_pkg::odsc_state_t state_r;
	odsc_pkg::odsc_state_t state_nxt;
	logic       armed;
	logic       auto_hit;
	logic       ref_edge;
	logic       fire_now;

	// True for a defined ratio code; reused by the status read and the valid output.
	function automatic logic ratio_ok(input logic [3:0] code);
		ratio_ok = (code >= `ODSC_RATIO_MIN) && (code <= `ODSC_RATIO_MAX);
	endfunction : ratio_ok

	// Status inputs come from other domains, so each passes two flip-flops.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s1_r <= 5'h00;
			s2_r <= 5'h00;
		end else begin
			s1_r <= {i_ref_active, i_dpll_phase_lock, i_dpll_freq_lock,
				i_loop_locked, i_loop_calibrated};
			s2_r <= s1_r;
		end
	end

	// Rising edge of the synchronised active reference.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ref_prev_r <= 1'b0;
		end else begin
			ref_prev_r <= s2_r[4];
		end
	end
	assign ref_edge = s2_r[4] && !ref_prev_r;

	assign armed = loop_ovr_r || (s2_r[0] && s2_r[1]);

	// auto trigger
	// Reserved code 11 behaves as disabled.
	always_comb begin
		case (auto_r)
			`ODSC_AUTO_FREQ:  auto_hit = s2_r[2];
			`ODSC_AUTO_PHASE: auto_hit = s2_r[3];
			default:          auto_hit = 1'b0;
		endcase
	end

	// Register writes; the sync command bit is a self-clearing request.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ratio_r      <= `ODSC_RST_PDIV_RATIO;
			pdiv_reset_r <= `ODSC_RST_PDIV_RESET;
			{src_sel_r, auto_r} <= `ODSC_RST_SYNC_CFG;
			{loop_ovr_r, mask_b_r, mask_a_r} <= `ODSC_RST_SYNC_MASK;
		end else if (i_wr) begin
			if (i_addr == `ODSC_OFF_PDIV_RATIO) begin
				ratio_r <= i_wdata[3:0];
			end else if (i_addr == `ODSC_OFF_PDIV_RESET) begin
				pdiv_reset_r <= i_wdata[`ODSC_BIT_PDIV_RESET];
			end else if (i_addr == `ODSC_OFF_SYNC_CFG) begin
				src_sel_r <= i_wdata[`ODSC_BIT_SRC_SEL];
				auto_r    <= i_wdata[1:0];
			end else if (i_addr == `ODSC_OFF_SYNC_MASK) begin
				loop_ovr_r <= i_wdata[`ODSC_BIT_LOOP_OVR];
				mask_b_r   <= i_wdata[`ODSC_BIT_MASK_B];
				mask_a_r   <= i_wdata[`ODSC_BIT_MASK_A];
			end
		end
	end

	// Manual request waits here until the pulse fires; a new write while it fires is kept.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cmd_pend_r <= 1'b0;
		end else if (i_wr && i_addr == `ODSC_OFF_SYNC_CMD && i_wdata[`ODSC_BIT_SYNC_CMD]) begin
			cmd_pend_r <= 1'b1;
		end else if (state_r == odsc_pkg::ODSC_FIRE) begin
			cmd_pend_r <= 1'b0;
		end
	end

	// Auto sync fires once per lock; it rearms only when the selected lock reads low or the field selects no trigger.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			auto_done_r <= 1'b0;
		end else if (!auto_hit) begin
			auto_done_r <= 1'b0;
		end else if (state_r == odsc_pkg::ODSC_FIRE) begin
			auto_done_r <= 1'b1;
		end
	end

	assign fire_now = armed && (cmd_pend_r || (auto_hit && !auto_done_r));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			odsc_pkg::ODSC_IDLE: begin
				if (fire_now) begin
					state_nxt = src_sel_r ? odsc_pkg::ODSC_ALIGN : odsc_pkg::ODSC_FIRE;
				end
			end
			odsc_pkg::ODSC_ALIGN: begin
				if (!armed) begin
					state_nxt = odsc_pkg::ODSC_IDLE;
				end else if (ref_edge) begin
					state_nxt = odsc_pkg::ODSC_FIRE;
				end
			end
			odsc_pkg::ODSC_FIRE: state_nxt = odsc_pkg::ODSC_IDLE;
			default:             state_nxt = odsc_pkg::ODSC_IDLE;
		endcase
	end

	// State register; one-hot codes let the status ALIGN bit read one flop.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= odsc_pkg::ODSC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// The pulse is registered so it reaches the dividers glitch free.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync_r <= 1'b0;
		end else begin
			sync_r <= (state_r == odsc_pkg::ODSC_FIRE);
		end
	end

	// channels a and b ignore
	// A held divider is released only by a pulse or by setting its mask bit, so unmasked ones start together.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hold_a_r <= 1'b1;
			hold_b_r <= 1'b1;
		end else begin
			if (mask_a_r) begin
				hold_a_r <= 1'b0;
			end else if (state_r == odsc_pkg::ODSC_FIRE) begin
				hold_a_r <= 1'b0;
			end
			if (mask_b_r) begin
				hold_b_r <= 1'b0;
			end else if (state_r == odsc_pkg::ODSC_FIRE) begin
				hold_b_r <= 1'b0;
			end
		end
	end

	// channel a and b release
	// The mask bypasses the hold flop so release does not wait for a clock edge.
	assign o_channel_a_output_hold = hold_a_r && !mask_a_r;
	assign o_channel_b_output_hold = hold_b_r && !mask_b_r;

	// no driver enable
	// This block has no driver enable output; masks touch only the hold lines.
	assign o_sync_pulse = sync_r;
	assign o_sync_armed = armed;

	assign o_post_divider_reset       = pdiv_reset_r;
	assign o_post_divider_ratio       = ratio_r;
	// software range
	// Divide-by-two legality depends on oscillator speed, which software must check.
	assign o_post_divider_ratio_valid = ratio_ok(ratio_r);

	// Read data appears in the cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			if (i_addr == `ODSC_OFF_PDIV_RATIO) begin
				o_rdata <= {4'h0, ratio_r};
			end else if (i_addr == `ODSC_OFF_PDIV_RESET) begin
				o_rdata <= {6'h00, pdiv_reset_r, 1'b0};
			end else if (i_addr == `ODSC_OFF_SYNC_CFG) begin
				o_rdata <= {5'h00, src_sel_r, auto_r};
			end else if (i_addr == `ODSC_OFF_SYNC_MASK) begin
				o_rdata <= {5'h00, loop_ovr_r, mask_b_r, mask_a_r};
			end else if (i_addr == `ODSC_OFF_STATUS) begin
				o_rdata <= {1'b0, ratio_ok(ratio_r), armed, cmd_pend_r,
					hold_b_r && !mask_b_r, hold_a_r && !mask_a_r, state_r[1], s2_r[1]};
			end else begin
				o_rdata <= 8'h00;
			end
		end else begin
			o_rdata <= 8'h00;
		end
	end

	AST_RATIO_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_wr && i_addr == `ODSC_OFF_PDIV_RATIO) |=> (ratio_r == $past(i_wdata[3:0])))
		else $error("Ratio code not stored.");
	AST_DIRECT_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_r == odsc_pkg::ODSC_IDLE && fire_now && !src_sel_r) |-> ##2 o_sync_pulse)
		else $error("Direct sync pulse late.");
	AST_ALIGNED_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		$rose(o_sync_pulse) && $past(src_sel_r, 2) |-> $past(ref_edge, 2))
		else $error("Aligned pulse not on reference edge.");
	AST_AUTO_RESERVED: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(auto_r == 2'h3) |-> !auto_hit)
		else $error("Reserved auto code triggered.");
	AST_LOCK_GATE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_r == odsc_pkg::ODSC_FIRE) |-> $past(armed))
		else $error("Sync fired while loop not locked.");
	AST_OVERRIDE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		loop_ovr_r |-> o_sync_armed)
		else $error("Override did not arm sync.");
	AST_MASK_B: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		mask_b_r |-> !o_channel_b_output_hold)
		else $error("Masked channel b held.");
	AST_MASK_A: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		mask_a_r |-> !o_channel_a_output_hold)
		else $error("Masked channel a held.");
	AST_HOLD_UNTIL_SYNC: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		$fell(hold_a_r) && !$past(mask_a_r) |-> $past(state_r == odsc_pkg::ODSC_FIRE))
		else $error("Channel a released without sync.");
	AST_PDIV_RESET: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(i_wr && i_addr == `ODSC_OFF_PDIV_RESET) |=> (o_post_divider_reset == $past(i_wdata[1])))
		else $error("Post-divider reset bit not applied.");
	AST_RATIO_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		!(i_wr && i_addr == `ODSC_OFF_PDIV_RATIO) |=> $stable(o_post_divider_ratio))
		else $error("Ratio code changed without a write.");
	AST_RATIO_VALID: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_post_divider_ratio_valid == (o_post_divider_ratio >= `ODSC_RATIO_MIN
			&& o_post_divider_ratio <= `ODSC_RATIO_MAX))
		else $error("Ratio valid flag wrong.");
	AST_PDIV_RESET_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		!(i_wr && i_addr == `ODSC_OFF_PDIV_RESET) |=> $stable(o_post_divider_reset))
		else $error("Post-divider reset bit changed without a write.");
	AST_DIRECT_FIRE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_r == odsc_pkg::ODSC_IDLE && fire_now && !src_sel_r)
			|=> (state_r == odsc_pkg::ODSC_FIRE))
		else $error("Direct sync did not fire at once.");
	AST_ALIGN_WAITS: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(state_r == odsc_pkg::ODSC_ALIGN && !ref_edge) |=> (state_r != odsc_pkg::ODSC_FIRE))
		else $error("Aligned sync fired without a reference edge.");
	// The status inputs pass two flops, so a pin value is seen two edges later.
	// frequency and phase triggers
	AST_AUTO_FREQ_HIT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(auto_r == `ODSC_AUTO_FREQ) |-> (auto_hit == $past(i_dpll_freq_lock, 2)))
		else $error("Frequency lock trigger wrong.");
	AST_AUTO_PHASE_HIT: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(auto_r == `ODSC_AUTO_PHASE) |-> (auto_hit == $past(i_dpll_phase_lock, 2)))
		else $error("Phase lock trigger wrong.");
	AST_GATE_OPEN: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		($past(i_loop_calibrated, 2) && $past(i_loop_locked, 2)) |-> o_sync_armed)
		else $error("Sync not armed after calibration and lock.");
	AST_GATE_CLOSED: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		(!loop_ovr_r && !($past(i_loop_calibrated, 2) && $past(i_loop_locked, 2)))
			|-> !o_sync_armed)
		else $error("Sync armed while loop not ready.");
	AST_MASK_B_IGNORES: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		mask_b_r |=> !hold_b_r)
		else $error("Masked channel b hold flop still set.");
	AST_MASK_A_IGNORES: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		mask_a_r |=> !hold_a_r)
		else $error("Masked channel a hold flop still set.");
	AST_HOLD_B_UNTIL_SYNC: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		$fell(hold_b_r) && !$past(mask_b_r) |-> $past(state_r == odsc_pkg::ODSC_FIRE))
		else $error("Channel b released without sync.");
	AST_PULSE_ONE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
		o_sync_pulse |=> !o_sync_pulse)
		else $error("Sync pulse longer than one cycle.");
endmodule : odsc_top

//--- verification/tb.sv
// Self-checking testbench for the output divider sync control block.
`timescale 1ns/1ns
`include "odsc_consts.svh"
module tb;
	logic        i_core_clk;
	logic        i_reset_n;
	logic [11:0] i_addr;
	logic [7:0]  i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [7:0]  o_rdata;
	logic        i_loop_calibrated;
	logic        i_loop_locked;
	logic        i_dpll_freq_lock;
	logic        i_dpll_phase_lock;
	logic        i_ref_active;
	logic [3:0]  o_post_divider_ratio;
	logic        o_post_divider_reset;
	logic        o_post_divider_ratio_valid;
	logic        o_channel_a_output_hold;
	logic        o_channel_b_output_hold;
	logic        o_sync_pulse;
	logic        o_sync_armed;
	int          fails;
	int          check_count;
	logic [3:0]  code;

	odsc_top i_odsc_top (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_loop_calibrated(i_loop_calibrated), .i_loop_locked(i_loop_locked),
		.i_dpll_freq_lock(i_dpll_freq_lock), .i_dpll_phase_lock(i_dpll_phase_lock),
		.i_ref_active(i_ref_active), .o_post_divider_ratio(o_post_divider_ratio),
		.o_post_divider_reset(o_post_divider_reset),
		.o_post_divider_ratio_valid(o_post_divider_ratio_valid),
		.o_channel_a_output_hold(o_channel_a_output_hold),
		.o_channel_b_output_hold(o_channel_b_output_hold),
		.o_sync_pulse(o_sync_pulse), .o_sync_armed(o_sync_armed));

	// Free-running core clock, 100 ns period.
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end

	// Expected validity of a ratio code.
	function automatic logic [7:0] ratio_ok(input logic [3:0] c);
		return {7'h0, (c >= `ODSC_RATIO_MIN) && (c <= `ODSC_RATIO_MAX)};
	endfunction : ratio_ok

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic conclude();
		$display("Checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : conclude

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read data is looked at only in the cycle after the strobe.
	task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		chk(name, exp, o_rdata);
	endtask : rd

	// A pulse lasts one cycle, so every cycle of the window is sampled.
	task automatic expect_pulse(input string name, input logic exp, input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge i_core_clk);
			#1;
			if (o_sync_pulse === 1'b1) seen = 1'b1;
		end
		chk(name, {7'h0, exp}, {7'h0, seen});
	endtask : expect_pulse

	// Status inputs are dropped during reset so each scenario starts unlocked.
	task automatic do_reset();
		@(posedge i_core_clk);
		i_reset_n <= 1'b0;
		{i_loop_calibrated, i_loop_locked, i_dpll_freq_lock} <= 3'h0;
		{i_dpll_phase_lock, i_ref_active} <= 2'h0;
		repeat (6) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
	endtask : do_reset

	task automatic holds(input logic [1:0] exp, input string name);
		#1;
		chk(name, {6'h0, exp}, {6'h0, o_channel_b_output_hold, o_channel_a_output_hold});
	endtask : holds

	// Watchdog sized well above the expected run length.
	initial begin
		#(100 * 20000);
		fails++;
		conclude();
	end

	initial begin
		{i_addr, i_wdata, i_wr, i_rd} = '0;
		{i_loop_calibrated, i_loop_locked, i_dpll_freq_lock} = 3'h0;
		{i_dpll_phase_lock, i_ref_active, i_reset_n} = 3'h0;
		fails = 0;
		check_count = 0;
		void'($urandom(12));
		do_reset();
		rd(`ODSC_OFF_PDIV_RATIO, 8'h00, "ratio_rst");
		rd(`ODSC_OFF_SYNC_CFG, 8'h00, "cfg_rst");
		rd(`ODSC_OFF_SYNC_MASK, 8'h00, "mask_rst");
		rd(12'h437, 8'h00, "unmapped");
		holds(2'h3, "hold_rst");
		// divide by two
		// Code 2 is fair game here: the bench stands for a slow oscillator.
		// Corner codes first, then random codes.
		for (int k = 0; k < 22; k++) begin
			code = (k < 6) ? 4'((k < 3) ? k : k + 8) : 4'($urandom_range(15));
			wr(`ODSC_OFF_PDIV_RATIO, {4'h0, code});
			#1;
			chk("ratio", {4'h0, code}, {4'h0, o_post_divider_ratio});
			chk("ratio_valid", ratio_ok(code), {7'h0, o_post_divider_ratio_valid});
		end
		wr(`ODSC_OFF_PDIV_RESET, 8'h02);
		#1;
		chk("pdiv_reset", 8'h01, {7'h0, o_post_divider_reset});
		wr(`ODSC_OFF_PDIV_RESET, 8'h00);
		#1;
		chk("pdiv_run", 8'h00, {7'h0, o_post_divider_reset});
		// Gate held closed until calibrated and locked; request stays pending.
		wr(`ODSC_OFF_SYNC_CMD, 8'h01);
		expect_pulse("gated", 1'b0, 10);
		@(posedge i_core_clk) i_loop_calibrated <= 1'b1;
		expect_pulse("cal_only", 1'b0, 8);
		chk("armed_cal", 8'h00, {7'h0, o_sync_armed});
		@(posedge i_core_clk) i_loop_locked <= 1'b1;
		expect_pulse("armed_fire", 1'b1, 8);
		chk("armed_lock", 8'h01, {7'h0, o_sync_armed});
		holds(2'h0, "restart");
		rd(`ODSC_OFF_STATUS, (ratio_ok(code) << 6) | 8'h21, "status_fired");
		// Override ignores lock; direct source fires at once.
		do_reset();
		wr(`ODSC_OFF_SYNC_MASK, 8'h04);
		#1;
		chk("armed_ovr", 8'h01, {7'h0, o_sync_armed});
		wr(`ODSC_OFF_SYNC_CMD, 8'h01);
		expect_pulse("direct", 1'b1, 6);
		// Aligned source waits for a reference edge.
		do_reset();
		wr(`ODSC_OFF_SYNC_MASK, 8'h04);
		wr(`ODSC_OFF_SYNC_CFG, 8'h04);
		wr(`ODSC_OFF_SYNC_CMD, 8'h01);
		expect_pulse("no_ref", 1'b0, 10);
		rd(`ODSC_OFF_STATUS, 8'h3e, "status_align");
		rd(`ODSC_OFF_SYNC_CFG, 8'h04, "cfg_back");
		@(posedge i_core_clk) i_ref_active <= 1'b1;
		expect_pulse("ref_edge", 1'b1, 8);
		// Masked channel runs free at once and is left out of the sync.
		do_reset();
		wr(`ODSC_OFF_SYNC_MASK, 8'h02);
		holds(2'h1, "mask_b");
		wr(`ODSC_OFF_SYNC_MASK, 8'h07);
		holds(2'h0, "mask_ab");
		rd(`ODSC_OFF_SYNC_MASK, 8'h07, "mask_back");
		do_reset();
		wr(`ODSC_OFF_SYNC_MASK, 8'h05);
		holds(2'h2, "mask_a");
		wr(`ODSC_OFF_SYNC_CMD, 8'h01);
		expect_pulse("masked_sync", 1'b1, 6);
		holds(2'h0, "b_synced");
		// Every automatic trigger code against both lock events.
		for (int m = 0; m < 4; m++) begin
			do_reset();
			wr(`ODSC_OFF_SYNC_MASK, 8'h04);
			wr(`ODSC_OFF_SYNC_CFG, 8'(m));
			@(posedge i_core_clk) i_dpll_freq_lock <= 1'b1;
			expect_pulse("auto_freq", 1'(m == 1), 8);
			@(posedge i_core_clk) i_dpll_phase_lock <= 1'b1;
			expect_pulse("auto_phase", 1'(m == 2), 8);
		end
		conclude();
	end
endmodule : tb
